// ==== rcr_consts.vh ====
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH

// register map, byte addresses on the apb bus
`define RCR_CTRL_ADDR      12'h000
`define RCR_STAT_ADDR      12'h004
`define RCR_WDATA_ADDR     12'h008
`define RCR_RDATA_ADDR     12'h00c
`define RCR_CFG_ADDR       12'h010

// control fields
`define RCR_CTRL_EN_BIT    0
`define RCR_CTRL_CLR_BIT   1
`define RCR_CTRL_USE_EN    2
`define RCR_CTRL_USE_CLR   3
`define RCR_CTRL_RESET     4'h0

// status fields
`define RCR_STAT_FULL_BIT  0
`define RCR_STAT_EMPTY_BIT 1
`define RCR_STAT_OVAL_BIT  2
`define RCR_STAT_SIGN_BIT  3

// datapath shape: l integer bits plus r fraction bits
`define RCR_L_BITS         24
`define RCR_R_BITS         8
`define RCR_DW             32
`define RCR_STAGES         2
`define RCR_FIFO_DEPTH     32
`define RCR_FIFO_AW        5

`endif

// ==== rcr_fifo.v ====
`include "rcr_consts.vh"

// synchronous fifo, write side fills, read side drains
module rcr_fifo #(
  parameter WIDTH = `RCR_DW,
  parameter DEPTH = `RCR_FIFO_DEPTH,
  parameter AW    = `RCR_FIFO_AW
) (
  input  wire             pclk,     // clock
  input  wire             presetn,  // async reset, low
  input  wire [WIDTH-1:0] in_data,  // fill data
  input  wire             in_valid, // fill request
  output wire             in_ready, // room left
  output wire [WIDTH-1:0] out_data, // head word
  output wire             out_valid,// not empty
  input  wire             out_ready // drain accept
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_r;
  reg [AW:0]      rp_r;
  wire            full;
  wire            empty;

  // pointers carry one wrap bit for honest full and empty
  assign full      = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign empty     = (wp_r == rp_r);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rp_r[AW-1:0]];

  // storage array has no reset
  always @(posedge pclk) begin
    if (in_valid && !full) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  // pointer update
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // rcr_fifo

// ==== rcr_rate_crossing_register.v ====
// Implementation choices: the address map and the APB interface to the registers.
`include "rcr_consts.vh"

// Function
// - capture input on clock edge, output after configured stages, at least one
// - extra stages act as synchroniser flops reducing metastability at output; here input and chain share the base clock, so they only add delay
// - with gate option, chain advances only while gate is asserted
// - with clear option, clear empties chain at every clock edge while it is set
// - chain is clocked by the base clock only
// - input and output share width of l integer plus r fraction bits
// - signed formats keep the msb as sign bit, passed unchanged
module rcr_rate_crossing_register (
  input  wire        pclk,    // base clock, 200 mhz
  input  wire        presetn, // async reset, low
  input  wire [11:0] paddr,   // apb address
  input  wire        psel,    // apb select
  input  wire        penable, // apb access phase
  input  wire        pwrite,  // apb direction
  input  wire [31:0] pwdata,  // apb write data
  output wire [31:0] prdata,  // apb read data
  output wire        pready,  // apb ready
  output wire        pslverr  // apb error
);

  // datapath shape: the word is l integer bits over r fraction bits,
  // and the chain depth is fixed at build time; all three are reported
  // back to software through the shape word at the cfg offset
  localparam       DW  = `RCR_DW;
  localparam       NS  = `RCR_STAGES;
  localparam       FD  = `RCR_FIFO_DEPTH;
  localparam       AW  = `RCR_FIFO_AW;
  localparam [7:0] LB8 = `RCR_L_BITS;
  localparam [7:0] RB8 = `RCR_R_BITS;
  localparam [7:0] NS8 = `RCR_STAGES;

  // programming model
  //   ctrl  : bit 0 gate level, bit 1 clear level, bit 2 arms the gate,
  //           bit 3 arms the clear; all zero after reset
  //   stat  : bit 0 buffer full, bit 1 buffer not empty, bit 2 output
  //           word waiting, bit 3 sign of the held word
  //   wdata : a write pushes one word into the buffer
  //   rdata : a read returns the held word and frees the holding register
  //   cfg   : read-only shape word, l bits, r bits and chain depth; a
  //           driver can check that the shape is the one it expects
  // timing
  //   a word written at one edge can be read back about three edges later
  //   with the gate open and the holding register empty; each further
  //   stage of depth adds one edge
  // limitations
  //   the chain runs on the base clock only; a word from another clock
  //   domain must arrive through a dual-clock buffer, not through here
  //   a word written to a full buffer is lost without any error
  //   the clear is a level: it keeps clearing until software drops it

  // control word: gate level, clear level, gate option, clear option
  reg  [3:0]       ctrl_r;
  reg  [3:0]       ctrl_nxt;

  // register chain, stage k in bits k*dw +: dw, with a valid bit per stage
  reg  [NS*DW-1:0] chain_r;
  reg  [NS*DW-1:0] chain_nxt;
  reg  [NS-1:0]    sval_r;
  reg  [NS-1:0]    sval_nxt;

  // output holding register seen by software at the rdata offset
  reg  [DW-1:0]    rdata_r;
  reg  [DW-1:0]    rdata_nxt;
  reg              rvalid_r;
  reg              rvalid_nxt;

  // read side of the bus: word and take permission caught in setup
  reg  [31:0]      prdata_r;
  reg  [31:0]      prdata_nxt;
  reg              take_ok_r;
  reg              take_ok_nxt;
  reg  [31:0]      mux_word;

  // bus decode
  wire             setup;
  wire             acc;
  wire             wr;
  wire             rd;
  wire             sel_ctrl;
  wire             sel_stat;
  wire             sel_wdata;
  wire             sel_rdata;
  wire             sel_cfg;
  wire             mapped;
  wire             push;

  // buffer and chain handshakes
  wire             f_in_ready;
  wire [DW-1:0]    f_out_data;
  wire             f_out_valid;
  wire             use_en;
  wire             use_clr;
  wire             gate_open;
  wire             clr;
  wire             stall;
  wire             adv;
  wire             deliver;
  wire             out_take;
  wire [DW-1:0]    last_word;
  wire [31:0]      stat_word;
  wire [31:0]      shape_word;
  integer          i;

  // address compare, shared by every register select below
  function is_addr;
    input [11:0] a;
    input [11:0] ref_a;
    begin
      is_addr = (a == ref_a);
    end
  endfunction

  // status word packing; the sign bit of the held word rides along so
  // software can test the sign without a full read
  function [31:0] pack_stat;
    input full;
    input not_empty;
    input out_valid;
    input sign;
    begin
      pack_stat = {28'h000_0000, sign, out_valid, not_empty, full};
    end
  endfunction

  // apb phase decode: setup is select without enable, access has both
  assign setup     = psel && !penable;
  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign rd        = acc && !pwrite;

  // register selects; anything else in the window is refused
  assign sel_ctrl  = is_addr(paddr, `RCR_CTRL_ADDR);
  assign sel_stat  = is_addr(paddr, `RCR_STAT_ADDR);
  assign sel_wdata = is_addr(paddr, `RCR_WDATA_ADDR);
  assign sel_rdata = is_addr(paddr, `RCR_RDATA_ADDR);
  assign sel_cfg   = is_addr(paddr, `RCR_CFG_ADDR);
  assign mapped    = sel_ctrl || sel_stat || sel_wdata || sel_rdata || sel_cfg;

  // zero wait states; an unmapped access errors and changes nothing
  assign pready    = 1'b1;
  assign pslverr   = acc && !mapped;
  assign push      = wr && sel_wdata;

  // input buffer fed by wdata writes; a write while it is full is
  // dropped without an error, so software should poll the full bit
  // before it sends a burst longer than the buffer
  rcr_fifo #(
    .WIDTH (DW),
    .DEPTH (FD),
    .AW    (AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (pwdata),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (adv)
  );

  // gate and clear options, each armed by its own ctrl bit; with an
  // option disarmed its level bit has no effect at all
  assign use_en    = ctrl_r[`RCR_CTRL_USE_EN];
  assign use_clr   = ctrl_r[`RCR_CTRL_USE_CLR];
  assign gate_open = !use_en || ctrl_r[`RCR_CTRL_EN_BIT];
  assign clr       = use_clr && ctrl_r[`RCR_CTRL_CLR_BIT];

  // backpressure: while a word waits in the output register and the
  // last stage is full, the whole chain holds so nothing is overwritten
  assign last_word = chain_r[(NS-1)*DW +: DW];
  assign stall     = rvalid_r && sval_r[NS-1];
  assign adv       = !clr && gate_open && !stall;
  assign deliver   = adv && sval_r[NS-1];

  // a read of rdata consumes the word only if it was valid when the
  // setup cycle captured it; a word landing between setup and access
  // stays put for the next read instead of being lost
  assign out_take  = rd && sel_rdata && take_ok_r;

  // control register next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr && sel_ctrl) begin
      ctrl_nxt = pwdata[3:0];
    end
  end

  // control register, cleared by reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `RCR_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // chain next value: a clear wins over an advance, and a held chain
  // keeps every stage as it is
  always @* begin
    i         = 0;
    chain_nxt = chain_r;
    sval_nxt  = sval_r;
    if (clr) begin
      chain_nxt = {(NS*DW){1'b0}}; // synchronous clear
      sval_nxt  = {NS{1'b0}};
    end else if (adv) begin
      chain_nxt[DW-1:0] = f_out_data; // capture whole word, msb sign kept
      sval_nxt[0]       = f_out_valid;
      for (i = 1; i < NS; i = i + 1) begin
        chain_nxt[i*DW +: DW] = chain_r[(i-1)*DW +: DW]; // further stages, each one more edge of delay on the base clock
        sval_nxt[i]           = sval_r[i-1];
      end
    end
  end

  // register chain on the base clock, zero after reset so the output
  // is defined before the first word has passed through
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_r <= {(NS*DW){1'b0}};
      sval_r  <= {NS{1'b0}};
    end else begin
      chain_r <= chain_nxt;
      sval_r  <= sval_nxt;
    end
  end

  // output register next value; a word arrives only while the holding
  // register is empty, so arrival and a read never meet in one cycle
  always @* begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = rvalid_r;
    if (clr) begin
      rdata_nxt  = {DW{1'b0}};
      rvalid_nxt = 1'b0;
    end else if (deliver) begin
      rdata_nxt  = last_word;
      rvalid_nxt = 1'b1;
    end else if (out_take) begin
      rvalid_nxt = 1'b0;
    end
  end

  // output holding register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r  <= {DW{1'b0}};
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // words that software can read
  assign stat_word  = pack_stat(!f_in_ready, f_out_valid, rvalid_r, rdata_r[DW-1]);
  assign shape_word = {8'h00, LB8, RB8, NS8};

  // read mux by address
  always @* begin
    mux_word = 32'h0000_0000;
    if (sel_ctrl) begin
      mux_word = {28'h000_0000, ctrl_r};
    end else if (sel_stat) begin
      mux_word = stat_word;
    end else if (sel_rdata) begin
      mux_word = rdata_r;
    end else if (sel_cfg) begin
      mux_word = shape_word;
    end
  end

  // read data is taken from the mux in the setup cycle, so prdata comes
  // from a flip-flop yet stands from the first access cycle on; a status
  // read therefore shows the state of the setup cycle
  always @* begin
    prdata_nxt  = prdata_r;
    take_ok_nxt = take_ok_r;
    if (setup) begin
      prdata_nxt  = mux_word;
      take_ok_nxt = rvalid_r;
    end
  end

  // read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      take_ok_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      take_ok_r <= take_ok_nxt;
    end
  end

  // bus read data straight from its register
  assign prdata = prdata_r;
endmodule // rcr_rate_crossing_register

// ==== rcr_monitor.sv ====
module rcr_monitor (
  input logic        pclk,    // clock
  input logic        presetn, // reset, low
  input logic [11:0] paddr,   // addr
  input logic        psel,    // select
  input logic        penable, // access
  input logic        pwrite,  // dir
  input logic [31:0] pwdata,  // wdata
  input logic [31:0] prdata,  // rdata
  input logic        pready,  // ready
  input logic        pslverr  // error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access-phase qualifiers
  logic acc, rd;
  assign acc = psel & penable;
  assign rd  = acc & ~pwrite;
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; acc && paddr > 12'h010 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  property p_ok; acc && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped");
  property p_idle; !acc |-> !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("error outside access");
  property p_cfg; rd && paddr == 12'h010 |-> prdata == 32'h00180802; endproperty
  a_cfg: assert property (p_cfg) else $error("bad shape word");
  property p_hi; rd && paddr == 12'h004 |-> prdata[31:4] == 28'h0; endproperty
  a_hi: assert property (p_hi) else $error("status high bits");
  property p_fe; rd && paddr == 12'h004 && prdata[0] |-> prdata[1]; endproperty
  a_fe: assert property (p_fe) else $error("full yet empty");
  property p_clr;
    acc && pwrite && paddr == 12'h000 && pwdata[3:0] == 4'ha ##3 rd && paddr == 12'h004
      |-> !prdata[2];
  endproperty
  a_clr: assert property (p_clr) else $error("clear left output");
  c_wr: cover property (acc && pwrite && paddr == 12'h008);
  c_rd: cover property (rd && paddr == 12'h00c);
  c_err: cover property (acc && pslverr);
endmodule // rcr_monitor
bind rcr_rate_crossing_register rcr_monitor u_mon (.*);

// ==== rcr_apb_host.sv ====
// upstream/downstream logic, seen through the register bus
module rcr_apb_host (
  input  logic        pclk,    // clock
  output logic [11:0] paddr,   // addr
  output logic        psel,    // select
  output logic        penable, // access
  output logic        pwrite,  // dir
  output logic [31:0] pwdata,  // wdata
  input  logic [31:0] prdata,  // rdata
  input  logic        pready,  // ready
  input  logic        pslverr  // error
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {paddr, psel, penable, pwrite, pwdata} = '0;
  // one transfer on the base clock only, no other domain involved
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule // rcr_apb_host

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  int fails = 0, n_tests = 0;
  initial forever #2.5 pclk = ~pclk;
  rcr_rate_crossing_register u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr);
  rcr_apb_host u_h (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr);
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_h.xfer(1'b1, a, d, v, er);
  endtask
  task rd(input logic [11:0] a);
    u_h.xfer(1'b0, a, 32'h0, v, er);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #20000;
    fails++;
    close_out;
  end
  // test sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000); chk(v, 32'h0);
    rd(12'h00c); chk(v, 32'h0);
    rd(12'h010); chk(v, 32'h00180802);
    $display("reset test done");
    wr(12'h008, 32'h800000a5); repeat (8) @(posedge pclk);
    rd(12'h004); chk(v, 32'hc);
    rd(12'h00c); chk(v, 32'h800000a5);
    rd(12'h004); chk(v, 32'h8);
    $display("sign test done");
    wr(12'h000, 32'h4); wr(12'h008, 32'h1234); repeat (8) @(posedge pclk);
    rd(12'h004); chk(v[2], 1'b0);
    wr(12'h000, 32'h5); repeat (8) @(posedge pclk);
    rd(12'h00c); chk(v, 32'h1234);
    $display("gate test done");
    wr(12'h008, 32'h5a); repeat (8) @(posedge pclk);
    wr(12'h000, 32'ha); rd(12'h004); chk(v[2], 1'b0);
    wr(12'h000, 32'h0);
    rd(12'h020); chk(er, 1'b1);
    $display("clear and error test done");
    for (int i = 0; i < 40; i++) wr(12'h008, i);
    rd(12'h004); chk(v[0], 1'b1);
    for (int i = 0; i < 34; i++) begin
      rd(12'h00c); chk(v, i);
    end
    rd(12'h004); chk(v, 32'h0);
    $display("fill test done");
    close_out;
  end
endmodule // testbench
